// *** rtl/ncp_regs.sv ***
//----------------------------------------------------------------------
// Purpose: Status, control, tag and pointer registers of the coprocessor
// Assumes: Single clock, datapath and host handshake are outside
//----------------------------------------------------------------------
`timescale 1ns/100ps

module ncp_regs #(
    parameter int NUM_REGS = 8,
    parameter int NUM_EXC  = 6
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Word loads from the host data channel
    input  wire logic                cw_load,
    input  wire logic [15:0]         cw_load_data,
    input  wire logic                tw_load,
    input  wire logic [15:0]         tw_load_data,
    input  wire logic                exc_clear,
    // Execution unit status
    input  wire logic                exec_busy,
    input  wire logic [NUM_EXC-1:0]  exc_detect,
    input  wire logic                cc_update,
    input  wire logic [3:0]          cc_value,
    input  wire logic                stack_push,
    input  wire logic                stack_pop,
    input  wire logic                tag_upd,
    input  wire logic [2:0]          tag_upd_idx,
    input  wire logic [1:0]          tag_upd_val,
    input  wire logic                int_operand,
    // Instruction issue
    input  wire logic                insn_issue,
    input  wire logic                prot_mode,
    input  wire logic                has_prefix,
    input  wire logic [31:0]         prefix_addr,
    input  wire logic [31:0]         escape_addr,
    input  wire logic                has_operand,
    input  wire logic [31:0]         operand_addr,
    input  wire logic [10:0]         insn_opcode,
    // Environment store requests
    input  wire logic                store_environment_op,
    input  wire logic                save_full_state_op,
    // Register read-back
    output logic      [15:0]         status_word_ff,
    output logic      [15:0]         control_word_ff,
    output logic      [15:0]         tag_word_ff,
    // Options toward the datapath
    output logic      [1:0]          prec_sel_ff,
    output logic      [1:0]          round_sel_ff,
    output logic                     affine_inf_ff,
    // Error line toward the host
    output logic                     error_n_ff,
    // Environment image stream
    output logic                     env_valid_ff,
    output logic      [2:0]          env_idx_ff,
    output logic      [15:0]         env_data_ff
);

    //------------------------------------------------------------------
    // Internal state
    //------------------------------------------------------------------
    logic [NUM_EXC-1:0] exc_flags_ff;
    logic [NUM_EXC-1:0] nxt_exc_flags;
    logic [15:0]        ctrl_ff;
    logic [2:0]         top_ff;
    logic [3:0]         cc_ff;
    logic [1:0]         tags_ff [NUM_REGS];
    logic [31:0]        insn_ptr_ff;
    logic [31:0]        data_ptr_ff;
    logic [10:0]        opcode_ff;
    logic               ptr_prot_ff;
    logic               error_summary;
    logic [15:0]        nxt_status;
    logic [15:0]        tag_flat;
    logic [15:0]        env_word;
    logic [2:0]         env_cnt_ff;
    ncp_pkg::ncp_env_state_t env_state_ff;

    //------------------------------------------------------------------
    // Exception flags and error summary
    //------------------------------------------------------------------

    // Sticky flags; a new detection wins over a clear
    always_comb begin
        nxt_exc_flags = exc_flags_ff;
        if (exc_clear) begin
            nxt_exc_flags = '0;
        end
        nxt_exc_flags = nxt_exc_flags | exc_detect;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_flags_ff <= '0;
        end else begin
            exc_flags_ff <= nxt_exc_flags;
        end
    end

    // Unmasked flags raise the summary
    assign error_summary = |(nxt_exc_flags
                             & ~ctrl_ff[ncp_pkg::CW_MASK_LSB +: NUM_EXC]);

    // Error line, active low, registered with the status word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            error_n_ff <= 1'b1;
        end else begin
            error_n_ff <= ~error_summary;
        end
    end

    //------------------------------------------------------------------
    // Control word
    //------------------------------------------------------------------

    // Loaded only by a word transfer from memory
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= ncp_pkg::CW_RESET;
        end else if (cw_load) begin
            ctrl_ff <= cw_load_data & ncp_pkg::CW_WMASK;
        end
    end

    // Option fields decoded for the datapath
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prec_sel_ff   <= ncp_pkg::PC_64;
            round_sel_ff  <= ncp_pkg::NCP_RND_NEAREST;
            affine_inf_ff <= ncp_pkg::CW_RESET[ncp_pkg::CW_IC_BIT];
        end else begin
            // Integer work is never shortened by the precision field
            if (int_operand) begin
                prec_sel_ff <= ncp_pkg::PC_64;
            end else begin
                prec_sel_ff <= ctrl_ff[ncp_pkg::CW_PC_LSB +: 2];
            end
            round_sel_ff  <= ctrl_ff[ncp_pkg::CW_RC_LSB +: 2];
            affine_inf_ff <= ctrl_ff[ncp_pkg::CW_IC_BIT];
        end
    end

    // Same registered path for every precision, so no latency change
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_word_ff <= ncp_pkg::CW_RESET;
        end else begin
            control_word_ff <= ctrl_ff;
        end
    end

    //------------------------------------------------------------------
    // Stack top and condition codes
    //------------------------------------------------------------------

    // Push moves down, pop moves up; both together cancel
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            top_ff <= ncp_pkg::TOP_RESET;
        end else if (stack_push && !stack_pop) begin
            top_ff <= top_ff - 3'h1;
        end else if (stack_pop && !stack_push) begin
            top_ff <= top_ff + 3'h1;
        end
    end

    // Condition codes from the last arithmetic outcome
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cc_ff <= 4'h0;
        end else if (cc_update) begin
            cc_ff <= cc_value;
        end
    end

    //------------------------------------------------------------------
    // Tag word, one entry per physical register
    //------------------------------------------------------------------
    for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_tag
        // Whole-word load wins over a single update
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                tags_ff[gi] <= ncp_pkg::TW_RESET[2*gi +: 2];
            end else if (tw_load) begin
                tags_ff[gi] <= tw_load_data[2*gi +: 2];
            end else if (tag_upd && (tag_upd_idx == 3'(gi))) begin
                tags_ff[gi] <= tag_upd_val;
            end
        end
        assign tag_flat[2*gi +: 2] = tags_ff[gi];
    end

    // Tag read-back
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tag_word_ff <= ncp_pkg::TW_RESET;
        end else begin
            tag_word_ff <= tag_flat;
        end
    end

    //------------------------------------------------------------------
    // Status word
    //------------------------------------------------------------------

    // Assemble fields; bit 6 reads as zero
    always_comb begin
        nxt_status = 16'h0000;
        nxt_status[ncp_pkg::SW_EXC_LSB +: NUM_EXC] = nxt_exc_flags;
        nxt_status[ncp_pkg::SW_ES_BIT] = error_summary;
        nxt_status[ncp_pkg::SW_CC_LSB +: ncp_pkg::SW_CC_W] = cc_ff;
        nxt_status[ncp_pkg::SW_TOP_LSB +: ncp_pkg::SW_TOP_W] = top_ff;
        nxt_status[ncp_pkg::SW_BUSY_BIT] = exec_busy | error_summary;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_word_ff <= 16'h0000;
        end else begin
            status_word_ff <= nxt_status;
        end
    end

    //------------------------------------------------------------------
    // Instruction and operand pointer capture
    //------------------------------------------------------------------

    // Taken at each numeric instruction issue
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            insn_ptr_ff <= 32'h0000_0000;
            opcode_ff   <= 11'h000;
            ptr_prot_ff <= 1'b0;
        end else if (insn_issue) begin
            insn_ptr_ff <= has_prefix ? prefix_addr : escape_addr;
            opcode_ff   <= insn_opcode;
            ptr_prot_ff <= prot_mode;
        end
    end

    // Operand pointer only when the instruction has one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ptr_ff <= 32'h0000_0000;
        end else if (insn_issue && has_operand) begin
            data_ptr_ff <= operand_addr;
        end
    end

    //------------------------------------------------------------------
    // Environment store sequencer
    //------------------------------------------------------------------

    // Word formatter for the current index
    ncp_env_fmt u_env_fmt (
        .word_idx  (env_cnt_ff),
        .prot_mode (ptr_prot_ff),
        .ctrl_word (ctrl_ff),
        .stat_word (nxt_status),
        .tag_word  (tag_flat),
        .insn_ptr  (insn_ptr_ff),
        .data_ptr  (data_ptr_ff),
        .opcode    (opcode_ff),
        .env_word  (env_word)
    );

    // Seven words, one a cycle; requests while sending are ignored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            env_state_ff <= ncp_pkg::NCP_ENV_IDLE;
            env_cnt_ff   <= 3'h0;
        end else begin
            case (env_state_ff)
                ncp_pkg::NCP_ENV_IDLE: begin
                    env_cnt_ff <= 3'h0;
                    if (store_environment_op || save_full_state_op) begin
                        env_state_ff <= ncp_pkg::NCP_ENV_SEND;
                    end
                end
                ncp_pkg::NCP_ENV_SEND: begin
                    if (env_cnt_ff == ncp_pkg::ENV_LAST) begin
                        env_state_ff <= ncp_pkg::NCP_ENV_IDLE;
                        env_cnt_ff   <= 3'h0;
                    end else begin
                        env_cnt_ff <= env_cnt_ff + 3'h1;
                    end
                end
                default: begin
                    env_state_ff <= ncp_pkg::NCP_ENV_IDLE;
                    env_cnt_ff   <= 3'h0;
                end
            endcase
        end
    end

    // Registered stream outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            env_valid_ff <= 1'b0;
            env_idx_ff   <= 3'h0;
            env_data_ff  <= 16'h0000;
        end else begin
            env_valid_ff <= (env_state_ff == ncp_pkg::NCP_ENV_SEND);
            env_idx_ff   <= env_cnt_ff;
            env_data_ff  <= env_word;
        end
    end

endmodule

// *** rtl/ncp_pkg.sv ***
//----------------------------------------------------------------------
// Purpose: Constants for the numeric coprocessor register bank
// Assumes: 16-bit status, control and tag words
// Notes:   Field positions and reset values are named here only once
//----------------------------------------------------------------------
package ncp_pkg;

    // Status word fields
    localparam int          SW_EXC_LSB   = 0;
    localparam int          SW_EXC_W     = 6;
    localparam int          SW_ES_BIT    = 7;
    localparam int          SW_CC_LSB    = 8;
    localparam int          SW_CC_W      = 4;
    localparam int          SW_TOP_LSB   = 12;
    localparam int          SW_TOP_W     = 3;
    localparam int          SW_BUSY_BIT  = 15;

    // Control word fields
    localparam int          CW_MASK_LSB  = 0;
    localparam int          CW_PC_LSB    = 8;
    localparam int          CW_RC_LSB    = 10;
    localparam int          CW_IC_BIT    = 12;
    localparam logic [15:0] CW_RESET     = 16'h033F;
    localparam logic [15:0] CW_WMASK     = 16'h1F3F;

    // Tag word and stack top reset
    localparam logic [15:0] TW_RESET     = 16'hFFFF;
    localparam logic [2:0]  TOP_RESET    = 3'h0;

    // Precision control encodings
    localparam logic [1:0]  PC_24        = 2'h0;
    localparam logic [1:0]  PC_53        = 2'h2;
    localparam logic [1:0]  PC_64        = 2'h3;

    // Rounding control encodings
    typedef enum logic [1:0] {
        NCP_RND_NEAREST = 2'b00,
        NCP_RND_DOWN    = 2'b01,
        NCP_RND_UP      = 2'b10,
        NCP_RND_CHOP    = 2'b11
    } ncp_round_t;

    // Environment image
    localparam int          ENV_WORDS    = 7;
    localparam logic [2:0]  ENV_LAST     = 3'h6;
    localparam int          REAL_ADDR_W  = 20;
    localparam int          OPCODE_W     = 11;
    localparam int          PTR_W        = 32;

    // Environment store sequencer states
    typedef enum logic [0:0] {
        NCP_ENV_IDLE = 1'b0,
        NCP_ENV_SEND = 1'b1
    } ncp_env_state_t;

endpackage

// *** rtl/ncp_env_fmt.sv ***
//----------------------------------------------------------------------
// Purpose: Selects one word of the stored environment image
// Assumes: Pointers already captured by the register bank
// Notes:   Purely combinational; the caller registers the result
//----------------------------------------------------------------------
`timescale 1ns/100ps

module ncp_env_fmt (
    // Selection
    input  wire logic [2:0]  word_idx,
    input  wire logic        prot_mode,
    // Captured state
    input  wire logic [15:0] ctrl_word,
    input  wire logic [15:0] stat_word,
    input  wire logic [15:0] tag_word,
    input  wire logic [31:0] insn_ptr,
    input  wire logic [31:0] data_ptr,
    input  wire logic [10:0] opcode,
    // Result
    output logic      [15:0] env_word
);

    // Word order: control, status, tag, code pointer, data pointer
    always_comb begin
        env_word = 16'h0000;
        case (word_idx)
            3'h0: env_word = ctrl_word;
            3'h1: env_word = stat_word;
            3'h2: env_word = tag_word;
            3'h3: env_word = insn_ptr[15:0];
            3'h4: begin
                if (prot_mode) begin
                    env_word = insn_ptr[31:16];
                end else begin
                    env_word = {insn_ptr[19:16], 1'b0, opcode};
                end
            end
            3'h5: env_word = data_ptr[15:0];
            3'h6: begin
                if (prot_mode) begin
                    env_word = data_ptr[31:16];
                end else begin
                    env_word = {data_ptr[19:16], 12'h000};
                end
            end
            default: env_word = 16'h0000;
        endcase
    end

endmodule

// *** sim/ncp_regs_asserts.sv ***
//--------------------
// Purpose: Port checks of the register bank
// Assumes: Sees ncp_regs ports only
// Notes:   Bound to every ncp_regs instance
//--------------------
`timescale 1ns/100ps

module ncp_regs_asserts #(
    parameter int NUM_EXC = 6
) (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst_n,
    // Watched inputs
    input wire logic               cw_load,
    input wire logic               exc_clear,
    input wire logic [NUM_EXC-1:0] exc_detect,
    input wire logic               stack_push,
    input wire logic               stack_pop,
    input wire logic               store_environment_op,
    input wire logic               save_full_state_op,
    // Watched outputs
    input wire logic [15:0]        status_word_ff,
    input wire logic [15:0]        control_word_ff,
    input wire logic [1:0]         round_sel_ff,
    input wire logic               affine_inf_ff,
    input wire logic               error_n_ff,
    input wire logic               env_valid_ff,
    input wire logic [2:0]         env_idx_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Push with quiet neighbours, and a full stream
    sequence s_lone_push;
        !(stack_push || stack_pop) ##1 (stack_push && !stack_pop) ##1 !(stack_push || stack_pop);
    endsequence
    sequence s_seven_words;
        env_valid_ff[*7] ##1 !env_valid_ff;
    endsequence

    // Status, error, option, stack and environment stream relations
    a_error_pin: assert property (error_n_ff == !status_word_ff[7])
        else $error("error line disagrees with summary");
    a_summary_mask: assert property (!$past(cw_load) && !$past(cw_load, 2) |->
        status_word_ff[7] == |(status_word_ff[5:0] & ~control_word_ff[5:0]))
        else $error("summary not equal to unmasked flags");
    a_flag_sets: assert property (|exc_detect |=>
        (status_word_ff[5:0] & $past(exc_detect)) == $past(exc_detect))
        else $error("detected exception not flagged");
    a_flag_sticky: assert property (!exc_clear |=>
        (status_word_ff[5:0] & $past(status_word_ff[5:0])) == $past(status_word_ff[5:0]))
        else $error("flag dropped without clear");
    a_busy_summary: assert property (status_word_ff[7] |-> status_word_ff[15])
        else $error("busy bit low while signalling");
    a_round_opts: assert property (round_sel_ff == control_word_ff[11:10]
        && affine_inf_ff == control_word_ff[12])
        else $error("options differ from control word");
    a_stack_push: assert property (s_lone_push |=>
        status_word_ff[14:12] == $past(status_word_ff[14:12], 2) - 3'h1)
        else $error("push did not decrement top");
    a_env_run: assert property ($rose(env_valid_ff) |->
        env_idx_ff == 3'h0 ##0 s_seven_words)
        else $error("environment stream not seven words");
    a_env_cause: assert property ($rose(env_valid_ff) |->
        $past(store_environment_op, 2) || $past(save_full_state_op, 2)
        || $past(store_environment_op, 3) || $past(save_full_state_op, 3))
        else $error("stream without request");
endmodule

bind ncp_regs ncp_regs_asserts #(.NUM_EXC(NUM_EXC)) chk_u (.sys_clk, .rst_n, .cw_load,
    .exc_clear, .exc_detect, .stack_push, .stack_pop, .store_environment_op,
    .save_full_state_op, .status_word_ff, .control_word_ff, .round_sel_ff,
    .affine_inf_ff, .error_n_ff, .env_valid_ff, .env_idx_ff);

// *** sim/ncp_host_model.sv ***
//--------------------
// Purpose: Host side issuing numeric instructions
// Assumes: Bench calls the tasks; strobes last one edge
// Notes:   Released fields show inverted values
//--------------------
`timescale 1ns/100ps

module ncp_host_model (
    // Clock
    input wire logic        sys_clk,
    // Word loads and instruction issue
    output logic            cw_load,
    output logic     [15:0] cw_load_data,
    output logic            insn_issue,
    output logic            prot_mode,
    output logic            has_prefix,
    output logic     [31:0] prefix_addr,
    output logic     [31:0] escape_addr,
    output logic            has_operand,
    output logic     [31:0] operand_addr,
    output logic     [10:0] insn_opcode,
    output logic            store_environment_op,
    output logic            save_full_state_op,
    // Environment stream into memory
    input wire logic        env_valid_ff,
    input wire logic [2:0]  env_idx_ff,
    input wire logic [15:0] env_data_ff
);
    logic [15:0] env_mem [0:7];
    logic [15:0] env_cnt = 16'h0000;

    // Idle levels
    initial begin
        {cw_load, insn_issue, store_environment_op, save_full_state_op} = '0;
        {prot_mode, has_prefix, has_operand, cw_load_data, insn_opcode} = '0;
        {prefix_addr, escape_addr, operand_addr} = '0;
    end

    // Memory image written by the stream
    always @(posedge sys_clk) begin
        if (env_valid_ff) begin
            env_mem[env_idx_ff] <= env_data_ff;
            env_cnt             <= env_cnt + 16'h0001;
        end
    end

    // Word moved from memory into the control word
    task automatic load_cw(input logic [15:0] val);
        @(posedge sys_clk);
        #1;
        cw_load      = 1'b1;
        cw_load_data = val;
        @(posedge sys_clk);
        #1;
        cw_load      = 1'b0;
        cw_load_data = ~val;
    endtask

    // One escape instruction
    task automatic issue(input logic prot, input logic pfx, input logic [31:0] ip,
                         input logic [31:0] dp, input logic [10:0] op);
        @(posedge sys_clk);
        #1;
        {insn_issue, prot_mode, has_prefix, has_operand} = {1'b1, prot, pfx, pfx};
        {prefix_addr, escape_addr, operand_addr, insn_opcode} = {ip, ~ip, dp, op};
        @(posedge sys_clk);
        #1;
        {insn_issue, prot_mode, has_prefix, has_operand} = {1'b0, ~prot, ~pfx, ~pfx};
        {prefix_addr, escape_addr, operand_addr, insn_opcode} = ~{ip, ~ip, dp, op};
    endtask

    // Environment store or full save
    task automatic env_req(input logic full);
        @(posedge sys_clk);
        #1;
        {store_environment_op, save_full_state_op} = {!full, full};
        @(posedge sys_clk);
        #1;
        {store_environment_op, save_full_state_op} = 2'b00;
    endtask
endmodule

// *** sim/numeric_coproc_status_control_regs_test.sv ***
//--------------------
// Purpose: Self-checking bench of the register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Seeded random values with fixed corners
//--------------------
`timescale 1ns/100ps

module numeric_coproc_status_control_regs_test;
    logic        sys_clk, rst_n, tw_load, exc_clear, exec_busy, cc_update, stack_push;
    logic        stack_pop, tag_upd, int_operand, cw_load, insn_issue, prot_mode;
    logic        has_prefix, has_operand, store_environment_op, save_full_state_op;
    logic        affine_inf_ff, error_n_ff, env_valid_ff;
    logic [1:0]  tag_upd_val, prec_sel_ff, round_sel_ff;
    logic [2:0]  tag_upd_idx, env_idx_ff;
    logic [3:0]  cc_value;
    logic [5:0]  exc_detect;
    logic [10:0] insn_opcode;
    logic [15:0] tw_load_data, cw_load_data, status_word_ff, control_word_ff;
    logic [15:0] tag_word_ff, env_data_ff;
    logic [31:0] prefix_addr, escape_addr, operand_addr;
    int          error_cnt = 0;
    int          tests_run = 0;

    ncp_regs dut_u (.sys_clk, .rst_n, .cw_load, .cw_load_data, .tw_load, .tw_load_data,
        .exc_clear, .exec_busy, .exc_detect, .cc_update, .cc_value, .stack_push, .stack_pop,
        .tag_upd, .tag_upd_idx, .tag_upd_val, .int_operand, .insn_issue, .prot_mode,
        .has_prefix, .prefix_addr, .escape_addr, .has_operand, .operand_addr, .insn_opcode,
        .store_environment_op, .save_full_state_op, .status_word_ff, .control_word_ff,
        .tag_word_ff, .prec_sel_ff, .round_sel_ff, .affine_inf_ff, .error_n_ff,
        .env_valid_ff, .env_idx_ff, .env_data_ff);
    ncp_host_model host_u (.sys_clk, .cw_load, .cw_load_data, .insn_issue, .prot_mode,
        .has_prefix, .prefix_addr, .escape_addr, .has_operand, .operand_addr, .insn_opcode,
        .store_environment_op, .save_full_state_op, .env_valid_ff, .env_idx_ff, .env_data_ff);

    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #(3000 * 5);
        error_cnt++;
        final_report();
    end

    // Helpers and expectations
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic exp_sum(input logic [5:0] f, input logic [5:0] m);
        return |(f & ~m);
    endfunction
    function automatic logic [15:0] env_hi(input logic p, input logic [31:0] a,
                                           input logic [10:0] o);
        return p ? a[31:16] : {a[19:16], 1'b0, o};
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Test sequence
    initial begin
        logic [15:0] cw_exp, tw_exp, base;
        logic [31:0] r, ip, dp;
        {rst_n, tw_load, exc_clear, exec_busy, cc_update, stack_push, stack_pop} = '0;
        {tag_upd, int_operand, exc_detect, cc_value, tw_load_data} = '0;
        {tag_upd_idx, tag_upd_val} = '0;
        void'($urandom(35921));
        tick(6);
        rst_n = 1'b1;
        check("control", control_word_ff, ncp_pkg::CW_RESET);
        check("prec", prec_sel_ff, ncp_pkg::PC_64);
        check("status", status_word_ff, 16'h0000);
        check("tag", tag_word_ff, ncp_pkg::TW_RESET);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            r[i] = i[0];
            host_u.load_cw({8'h03, 2'h0, r[5:0]});
            exc_clear = 1'b1;
            tick(1);
            exc_clear = 1'b0;
            exc_detect = 6'h01 << i;
            tick(1);
            exc_detect = 6'h00;
            check("flag", status_word_ff[5:0], 6'h01 << i);
            check("summary", status_word_ff[7], exp_sum(6'h01 << i, r[5:0]));
            check("error_n", error_n_ff, !exp_sum(6'h01 << i, r[5:0]));
            check("busy", status_word_ff[15], exp_sum(6'h01 << i, r[5:0]));
            tick(4);
            check("sticky", status_word_ff[5:0], 6'h01 << i);
        end
        $display("exception test done");
        for (int k = 0; k < 16; k++) begin
            r = $urandom;
            cw_exp = {3'h0, r[0], k[3:0], 8'h3F};
            host_u.load_cw(cw_exp | 16'hE0C0);
            int_operand = (k == 0);
            tick(3);
            check("control", control_word_ff, cw_exp);
            check("prec", prec_sel_ff, k == 0 ? ncp_pkg::PC_64 : k[1:0]);
            check("round", round_sel_ff, k[3:2]);
            check("inf", affine_inf_ff, r[0]);
            int_operand = 1'b0;
        end
        exec_busy = 1'b1;
        tick(3);
        check("busy", status_word_ff[15], 1'b1);
        exec_busy = 1'b0;
        tick(3);
        check("idle", status_word_ff[15], 1'b0);
        $display("option test done");
        stack_push = 1'b1;
        tick(1);
        stack_push = 1'b0;
        tick(2);
        check("top", status_word_ff[14:12], 3'h7);
        stack_pop = 1'b1;
        tick(1);
        stack_pop = 1'b0;
        tick(2);
        check("top pop", status_word_ff[14:12], 3'h0);
        tw_exp = ncp_pkg::TW_RESET;
        for (int t = 0; t < 8; t++) begin
            r = $urandom;
            {tag_upd, tag_upd_idx, tag_upd_val} = {1'b1, t[2:0], r[1:0]};
            {cc_update, cc_value} = {1'b1, r[5:2]};
            tw_exp[2*t +: 2] = r[1:0];
            tick(1);
            {tag_upd, cc_update} = 2'b00;
            tick(2);
            check("tag", tag_word_ff, tw_exp);
            check("cc", status_word_ff[11:8], r[5:2]);
        end
        {tw_load, tw_load_data} = {1'b1, r[31:16]};
        tw_exp = r[31:16];
        tick(1);
        tw_load = 1'b0;
        tick(2);
        check("tag load", tag_word_ff, tw_exp);
        $display("tag test done");
        for (int m = 0; m < 2; m++) begin
            {r, ip} = {$urandom, $urandom};
            if (m == 0) dp = $urandom;
            host_u.issue(m[0], !m[0], ip, m[0] ? ~dp : dp, r[10:0]);
            base = host_u.env_cnt;
            host_u.env_req(m[0]);
            host_u.env_req(!m[0]);
            tick(12);
            if (m == 1) ip = ~ip;
            check("words", host_u.env_cnt - base, 16'h0007);
            check("env cw", host_u.env_mem[0], cw_exp);
            check("env tag", host_u.env_mem[2], tw_exp);
            check("env ip", host_u.env_mem[3], ip[15:0]);
            check("env ip hi", host_u.env_mem[4], env_hi(m[0], ip, r[10:0]));
            check("env dp", host_u.env_mem[5], dp[15:0]);
            check("env dp hi", host_u.env_mem[6], env_hi(m[0], dp, 11'h000));
        end
        $display("pointer test done");
        final_report();
    end
endmodule
